// [inc/srh_pkg.sv]
// Purpose: Constants and carrier types for the static memory host controller
// Assumes: 10 MHz clock, 1024 x 4 asynchronous memory on the far side
// Notes: Times are kept in ns, power-up wait in us; cycle counts derive from them
package srh_pkg;
  // Memory geometry
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 4;
  localparam int unsigned DEPTH = 1024;
  // Clock period in ns
  localparam int unsigned CLK_NS = 100;
  // Slowest grade figures, ns; power-up wait in us
  localparam int unsigned T_ACC_NS = 70;
  localparam int unsigned T_ACC_SLOW_NS = 80;
  localparam int unsigned T_CYC_NS = 70;
  localparam int unsigned T_WP_NS = 50;
  localparam int unsigned T_WZ_NS = 25;
  localparam int unsigned T_DESEL_NS = 55;
  localparam int unsigned T_PWRUP_US = 500;
  // Least times round up to whole cycles, never below one
  localparam int unsigned ACC_CYC = (T_ACC_SLOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_CYC = (T_CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WZ_CYC = (T_WZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DESEL_CYC = (T_DESEL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWRUP_CYC = T_PWRUP_US * 1000 / CLK_NS;
  // Counter width and reset constants
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

  // Controller states, one-hot
  typedef enum logic [5:0]
  {
    ST_PWRUP = 6'h01,
    ST_IDLE = 6'h02,
    ST_RSEL = 6'h04,
    ST_WSEL = 6'h08,
    ST_WPULSE = 6'h10,
    ST_DONE = 6'h20
  } srh_state_e;

  // Pin bundle driven to the memory
  typedef struct packed
  {
    logic [ADDR_W-1:0] word_index;
    logic unit_sel_n;
    logic write_strobe_n;
    logic [DATA_W-1:0] data_o;
    logic data_oe;
  } srh_pins_s;

  // User request
  typedef struct packed
  {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srh_req_s;
endpackage : srh_pkg

// [design/srh_timer.sv]
// Purpose: Down counter that paces pin phases
// Assumes: Load and enable come from the controller
// Notes: Reports done when the count has reached zero
`timescale 1ns/1ps
module srh_timer #(
  parameter int unsigned W = srh_pkg::CNT_W
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Control
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  // Status
  output logic done_out
);
  logic [W-1:0] count;

  // A counter without bits cannot pace anything
  initial
  begin
    if (W < 1)
      $error("W out of range");
  end

  // Load wins over counting
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      count <= '0;
    else if (ce_in)
    begin
      if (load_in)
        count <= value_in;
      else if (count != '0)
        count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Zero means phase time is over
  assign done_out = (count == '0);
endmodule : srh_timer

// [design/srh_host.sv]
// Purpose: Host sequencer for a 1024 x 4 asynchronous static memory
// Assumes: Memory pins are synchronous to clk_in; slowest speed grade timing
// Notes: One access at a time; request handshake valid/ready, read data registered
`timescale 1ns/1ps
module srh_host #(
  parameter int unsigned PWRUP_CYCLES = srh_pkg::PWRUP_CYC
)
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // User request
  input wire logic req_valid_in,
  input wire srh_pkg::srh_req_s req_in,
  output logic req_ready_out,
  // User answer
  output logic rdata_valid_out,
  output logic [srh_pkg::DATA_W-1:0] rdata_out,
  output logic init_done_out,
  // Memory pins
  output logic [srh_pkg::ADDR_W-1:0] word_index_out,
  output logic unit_sel_n_out,
  output logic write_strobe_n_out,
  output logic [srh_pkg::DATA_W-1:0] shared_data_lines_out,
  output logic shared_data_lines_oe_out,
  input wire logic [srh_pkg::DATA_W-1:0] shared_data_lines_in
);
  // Counts must fit the timer
  initial
  begin
    if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= (1 << srh_pkg::CNT_W))
      $error("PWRUP_CYCLES out of range");
  end

  // Sequencer state; pwr_loaded and the timer count are kept outside it
  typedef struct packed
  {
    srh_pkg::srh_state_e st;
    srh_pkg::srh_pins_s pins;
    logic [srh_pkg::DATA_W-1:0] rdata;
    logic rvalid;
    logic [srh_pkg::CNT_W-1:0] idle_cnt;
  } srh_state_s;

  srh_state_s cur;
  srh_state_s next_cur;
  logic tmr_load;
  logic [srh_pkg::CNT_W-1:0] tmr_val;
  logic tmr_done;
  logic pwr_loaded; // Power-up wait already loaded
  logic pwr_load; // First enabled cycle after reset
  logic tmr_load_any; // Load from sequencer or power-up path
  logic [srh_pkg::CNT_W-1:0] tmr_val_any; // Value for that load
  // Read access figure when deselected long enough
  localparam int unsigned ACC_FAST_CYC =
    (srh_pkg::T_ACC_NS + srh_pkg::CLK_NS - 1) / srh_pkg::CLK_NS;

  // Power-up wait loads once, on the first enabled cycle after reset
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pwr_loaded <= 1'b0;
    else if (ce_in)
      pwr_loaded <= 1'b1;
  end

  // Timer is shared; power-up load uses a side path
  assign pwr_load = !pwr_loaded;
  assign tmr_load_any = tmr_load || pwr_load;
  assign tmr_val_any = pwr_load ? srh_pkg::CNT_W'(PWRUP_CYCLES) : tmr_val;

  // Phase timer; without the side path the wait would be skipped
  srh_timer #(.W(srh_pkg::CNT_W)) u_timer
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .load_in(tmr_load_any),
    .value_in(tmr_val_any),
    .done_out(tmr_done)
  );

  // Ready only when idle and timer spent, so cycles keep their spacing
  assign req_ready_out = (cur.st == srh_pkg::ST_IDLE) && tmr_done;

  // Sequencer next state
  always_comb
  begin
    next_cur = cur;
    next_cur.rvalid = 1'b0;
    tmr_load = 1'b0;
    tmr_val = srh_pkg::CNT_ZERO;
    case (cur.st)
      srh_pkg::ST_PWRUP:
      begin
        // Memory stays deselected until bias settles
        // Timer reads zero before the wait is loaded, so wait for the load
        if (tmr_done && pwr_loaded)
          next_cur.st = srh_pkg::ST_IDLE;
      end
      srh_pkg::ST_IDLE:
      begin
        // Deselected long enough gives the fast access figure
        if (cur.idle_cnt < srh_pkg::CNT_W'(srh_pkg::DESEL_CYC))
          next_cur.idle_cnt = cur.idle_cnt + srh_pkg::CNT_ONE;
        if (req_valid_in && req_ready_out)
        begin
          // Address placed together with select, strobe stays high
          next_cur.pins.word_index = req_in.addr;
          next_cur.pins.unit_sel_n = 1'b0;
          tmr_load = 1'b1;
          if (req_in.write)
          begin
            next_cur.pins.data_o = req_in.wdata;
            next_cur.st = srh_pkg::ST_WSEL;
            tmr_val = srh_pkg::CNT_W'(srh_pkg::WZ_CYC);
          end
          else
          begin
            // Host keeps off the lines during a read
            next_cur.pins.data_oe = 1'b0;
            next_cur.st = srh_pkg::ST_RSEL;
            // Short deselect costs extra select access time
            if (cur.idle_cnt < srh_pkg::CNT_W'(srh_pkg::DESEL_CYC))
              tmr_val = srh_pkg::CNT_W'(srh_pkg::ACC_CYC);
            else
              tmr_val = srh_pkg::CNT_W'(ACC_FAST_CYC);
          end
        end
      end
      srh_pkg::ST_RSEL:
      begin
        // Sample after worst-case access, before address moves
        if (tmr_done)
        begin
          next_cur.rdata = shared_data_lines_in;
          next_cur.rvalid = 1'b1;
          next_cur.pins.unit_sel_n = 1'b1;
          next_cur.st = srh_pkg::ST_DONE;
        end
      end
      srh_pkg::ST_WSEL:
      begin
        // Strobe falls; host drives from the same edge that releases the memory drivers
        next_cur.pins.write_strobe_n = 1'b0;
        next_cur.pins.data_oe = 1'b1;
        next_cur.st = srh_pkg::ST_WPULSE;
        tmr_load = 1'b1;
        tmr_val = srh_pkg::CNT_W'(srh_pkg::WP_CYC);
      end
      srh_pkg::ST_WPULSE:
      begin
        // Strobe and select rise together; data held one more cycle
        if (tmr_done)
        begin
          next_cur.pins.write_strobe_n = 1'b1;
          next_cur.pins.unit_sel_n = 1'b1;
          next_cur.st = srh_pkg::ST_DONE;
        end
      end
      srh_pkg::ST_DONE:
      begin
        // Release data after strobe high, then enforce cycle spacing
        next_cur.pins.data_oe = 1'b0;
        next_cur.idle_cnt = srh_pkg::CNT_ZERO;
        next_cur.st = srh_pkg::ST_IDLE;
        tmr_load = 1'b1;
        tmr_val = srh_pkg::CNT_W'(srh_pkg::CYC_CYC);
      end
      default:
      begin
        next_cur.st = srh_pkg::ST_IDLE;
        next_cur.pins.unit_sel_n = 1'b1;
        next_cur.pins.write_strobe_n = 1'b1;
        next_cur.pins.data_oe = 1'b0;
      end
    endcase
  end

  // State register; pins idle deselected in reset
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cur.st <= srh_pkg::ST_PWRUP;
      cur.pins.word_index <= srh_pkg::ADDR_RST;
      cur.pins.unit_sel_n <= 1'b1;
      cur.pins.write_strobe_n <= 1'b1;
      cur.pins.data_o <= srh_pkg::DATA_RST;
      cur.pins.data_oe <= 1'b0;
      cur.rdata <= srh_pkg::DATA_RST;
      cur.rvalid <= 1'b0;
      cur.idle_cnt <= srh_pkg::CNT_ZERO;
    end
    else if (ce_in)
      cur <= next_cur;
  end

  // Outputs from flip-flops; init_done_out is decoded from the state register
  assign word_index_out = cur.pins.word_index;
  assign unit_sel_n_out = cur.pins.unit_sel_n;
  assign write_strobe_n_out = cur.pins.write_strobe_n;
  assign shared_data_lines_out = cur.pins.data_o;
  assign shared_data_lines_oe_out = cur.pins.data_oe;
  assign rdata_out = cur.rdata;
  assign rdata_valid_out = cur.rvalid;
  assign init_done_out = (cur.st != srh_pkg::ST_PWRUP);
endmodule : srh_host

// [sim/srh_host_monitor.sv]
// Purpose: Pin protocol checks for the memory host
// Assumes: Sees only srh_host ports
// Notes: Bound into every srh_host
`timescale 1ns/1ps
module srh_host_monitor #(parameter int unsigned PWRUP_CYCLES = srh_pkg::PWRUP_CYC)
(
  // Clock, reset, request
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input wire srh_pkg::srh_req_s req_in,
  input wire logic req_ready_out,
  // Answer
  input wire logic rdata_valid_out,
  input wire logic [3:0] rdata_out,
  input wire logic init_done_out,
  // Memory pins
  input wire logic [9:0] word_index_out,
  input wire logic unit_sel_n_out,
  input wire logic write_strobe_n_out,
  input wire logic [3:0] shared_data_lines_out,
  input wire logic shared_data_lines_oe_out,
  input wire logic [3:0] shared_data_lines_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic tk; // Request taken this edge
  logic [15:0] up_cnt; // Enabled cycles since reset, saturating
  assign tk = ce_in && req_valid_in && req_ready_out;
  // Saturate so a long run never wraps back under the wait
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) up_cnt <= 16'h0000;
    else if (ce_in && up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h0001;
  property p_take; tk |=> !unit_sel_n_out && word_index_out == $past(req_in.addr); endproperty
  a_take: assert property (p_take) else $error("select or index wrong");
  // Answer is registered two edges after the take, so it is sampled on the third
  property p_rd; tk && !req_in.write |-> ##3 rdata_valid_out; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rdata;
    rdata_valid_out |-> $past(!unit_sel_n_out && write_strobe_n_out)
      && rdata_out == $past(shared_data_lines_in);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not from lines");
  property p_hold; !unit_sel_n_out |=> unit_sel_n_out || $stable(word_index_out); endproperty
  a_hold: assert property (p_hold) else $error("index moved while selected");
  property p_addr;
    $changed(word_index_out) |-> $past(unit_sel_n_out) || $past(write_strobe_n_out);
  endproperty
  a_addr: assert property (p_addr) else $error("index moved during write");
  property p_we;
    !write_strobe_n_out |-> !unit_sel_n_out && shared_data_lines_oe_out
      && $stable(shared_data_lines_out);
  endproperty
  a_we: assert property (p_we) else $error("write pulse without data");
  property p_wp;
    $fell(write_strobe_n_out) |=> !write_strobe_n_out ##[1:4] write_strobe_n_out;
  endproperty
  a_wp: assert property (p_wp) else $error("write pulse length");
  property p_end; $rose(write_strobe_n_out) |-> $rose(unit_sel_n_out); endproperty
  a_end: assert property (p_end) else $error("strobe and select apart");
  property p_oe; shared_data_lines_oe_out |-> unit_sel_n_out || !write_strobe_n_out; endproperty
  a_oe: assert property (p_oe) else $error("drive during read");
  property p_pwr; !unit_sel_n_out |-> up_cnt >= PWRUP_CYCLES && init_done_out; endproperty
  a_pwr: assert property (p_pwr) else $error("select before wait");
  c_wr: cover property (tk && req_in.write);
  c_rd: cover property (rdata_valid_out);
  c_b2b: cover property (tk ##[1:8] tk);
endmodule : srh_host_monitor
bind srh_host srh_host_monitor #(.PWRUP_CYCLES(PWRUP_CYCLES)) srh_host_monitor_inst (.*);

// [sim/srh_sram_model.sv]
// Purpose: Behavioural 1024 x 4 static memory
// Assumes: Pins come from host registers
// Notes: Released lines show inverse of last level
`timescale 1ns/1ps
module srh_sram_model #(
  parameter int unsigned ACC_NS = 70,
  parameter int unsigned SHORT_DESEL_NS = 10
)
(
  // Memory pins
  input wire logic [9:0] word_index_in,
  input wire logic unit_sel_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [3:0] host_data_in,
  input wire logic host_oe_in,
  // Resolved shared lines
  output logic [3:0] shared_data_lines_out
);
  logic [3:0] mem [1024]; // Undefined until written, no clock
  logic [3:0] rd; // Word after access time
  logic [3:0] idle; // Level of released lines
  logic drive; // Memory drives lines
  // Deselected means drivers off and standby power
  assign drive = !unit_sel_n_in && write_strobe_n_in;
  // Unknown until access time passes, so early sampling shows
  // Always the slower short-deselect figure, the worst a host can meet
  // Inertial delay keeps the old word until the new one arrives
  assign #(ACC_NS + SHORT_DESEL_NS) rd = drive ? mem[word_index_in] : 4'hx;
  // Store is level sensitive while both low
  always @*
    if (!unit_sel_n_in && !write_strobe_n_in)
      mem[word_index_in] = shared_data_lines_out;
  // Contention yields unknown
  always @*
    if (host_oe_in && drive) shared_data_lines_out = 4'hx;
    else if (host_oe_in) shared_data_lines_out = host_data_in;
    else if (drive) shared_data_lines_out = rd;
    else shared_data_lines_out = idle;
  always @(shared_data_lines_out)
    if (host_oe_in || drive) idle = ~shared_data_lines_out;
endmodule : srh_sram_model

// [sim/srh_host_tb.sv]
// Purpose: Self-checking bench for the memory host
// Assumes: Behavioural memory on the pins
// Notes: Short power-up wait keeps the run brief
`timescale 1ns/1ps
module srh_host_tb;
  localparam int unsigned PWR = 4; // Shortened power-up wait
  logic clk_in;
  logic rst_n_in;
  logic ce_in;
  logic req_valid_in;
  srh_pkg::srh_req_s req_in;
  logic req_ready_out;
  logic rdata_valid_out;
  logic [3:0] rdata_out;
  logic init_done_out;
  logic [9:0] word_index_out;
  logic unit_sel_n_out;
  logic write_strobe_n_out;
  logic [3:0] shared_data_lines_out;
  logic shared_data_lines_oe_out;
  logic [3:0] dq; // Resolved lines
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  srh_host #(.PWRUP_CYCLES(PWR)) srh_host_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(ce_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rdata_valid_out(rdata_valid_out),
    .rdata_out(rdata_out), .init_done_out(init_done_out), .word_index_out(word_index_out),
    .unit_sel_n_out(unit_sel_n_out), .write_strobe_n_out(write_strobe_n_out),
    .shared_data_lines_out(shared_data_lines_out),
    .shared_data_lines_oe_out(shared_data_lines_oe_out), .shared_data_lines_in(dq));
  srh_sram_model srh_sram_model_inst (.word_index_in(word_index_out),
    .unit_sel_n_in(unit_sel_n_out), .write_strobe_n_in(write_strobe_n_out),
    .host_data_in(shared_data_lines_out), .host_oe_in(shared_data_lines_oe_out),
    .shared_data_lines_out(dq));
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // Hang guard, far above the roughly 100 cycles the run needs
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
    comparisons++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask : chk
  // One access; valid held until the edge that sees ready
  task automatic acc(input logic w, input logic [9:0] a, input logic [3:0] d,
    output logic [3:0] q);
    int n;
    @(negedge clk_in);
    req_valid_in = 1'b1;
    req_in = '{w, a, d};
    n = 0;
    while (req_ready_out !== 1'b1 && n < 50) begin @(negedge clk_in); n++; end
    chk("ready", 4'h1, {3'h0, req_ready_out});
    @(negedge clk_in);
    req_valid_in = 1'b0;
    n = 0;
    while (!w && rdata_valid_out !== 1'b1 && n < 5) begin @(negedge clk_in); n++; end
    q = rdata_out;
  endtask : acc
  task automatic t_reset;
    int n;
    repeat (20) @(negedge clk_in);
    chk("select", 4'h1, {3'h0, unit_sel_n_out});
    chk("drive", 4'h0, {3'h0, shared_data_lines_oe_out});
    rst_n_in = 1'b1;
    n = 0;
    while (init_done_out !== 1'b1 && n < 50) begin @(negedge clk_in); n++; end
    chk("wait", 4'h1, {3'h0, n >= PWR});
    $display("test reset done");
  endtask : t_reset
  task automatic t_rw;
    logic [9:0] a [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
    logic [3:0] d [4] = '{4'h5, 4'ha, 4'hf, 4'h0};
    logic [3:0] q;
    for (int i = 0; i < 4; i++) acc(1'b1, a[i], d[i], q);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b0, a[i], 4'h0, q);
      chk("word", d[i], q);
    end
    acc(1'b0, a[0], 4'h0, q);
    chk("reread", d[0], q);
    $display("test write read done");
  endtask : t_rw
  // A request while busy must be ignored
  task automatic t_refuse;
    logic [3:0] q;
    acc(1'b1, 10'h001, 4'h3, q);
    @(negedge clk_in);
    req_valid_in = 1'b1;
    req_in = '{1'b1, 10'h001, 4'hc};
    @(negedge clk_in);
    req_valid_in = 1'b0;
    acc(1'b0, 10'h001, 4'h0, q);
    chk("refused", 4'h3, q);
    $display("test refuse done");
  endtask : t_refuse
  // Enable low freezes the host; a request then must not start a cycle
  task automatic t_freeze;
    logic [3:0] q;
    @(negedge clk_in);
    ce_in = 1'b0;
    req_valid_in = 1'b1;
    req_in = '{1'b1, 10'h002, 4'h9};
    repeat (3) @(negedge clk_in);
    chk("frozen select", 4'h1, {3'h0, unit_sel_n_out});
    req_valid_in = 1'b0;
    ce_in = 1'b1;
    acc(1'b1, 10'h002, 4'h6, q);
    acc(1'b0, 10'h002, 4'h0, q);
    chk("after freeze", 4'h6, q);
    $display("test freeze done");
  endtask : t_freeze
  initial
  begin
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    req_valid_in = 1'b0;
    req_in = '{1'b0, 10'h000, 4'h0};
    t_reset();
    t_rw();
    t_refuse();
    t_freeze();
    tally_and_finish();
  end
endmodule : srh_host_tb
